// ===== verilog/cfb_defines.svh
// Constants of the configuration fallback boot controller.
// Assumes inclusion by bare name from the top module.
`ifndef CFB_DEFINES_SVH
`define CFB_DEFINES_SVH
// ******************************
// Register offsets (byte addresses)
// ******************************
`define CFB_ADDR_CTRL 8'h00
`define CFB_ADDR_WBSTART 8'h04
`define CFB_ADDR_CMD 8'h08
`define CFB_ADDR_STATUS 8'h0C
`define CFB_ADDR_HIST 8'h10
// ******************************
// Field positions
// ******************************
`define CFB_CTRL_FBDIS 0
`define CFB_CTRL_ENCRYPT 1
`define CFB_CTRL_SLVPAR 2
`define CFB_CTRL_MODE 4
`define CFB_CTRL_WDT_EN 8
`define CFB_CTRL_WDT_MON 9
`define CFB_WB_RS 26
`define CFB_CMD_INT_PROG 0
// ******************************
// Reset values and addresses
// ******************************
`define CFB_CTRL_RESET 32'h0000_0000
`define CFB_WB_RESET 28'h000_0000
`define CFB_ADDR_UP_DEF 26'h000_0000
`define CFB_ADDR_DOWN_DEF 26'h3FF_FFFF
`define CFB_ADDR_DOWN_FB 26'h00F_FFFF
`define CFB_RS_FALLBACK 2'h0
`define CFB_RESP_OKAY 2'h0
`define CFB_RESP_SLVERR 2'h2
// ******************************
// Timing
// ******************************
`define CFB_CLK_PERIOD_NS 8
`define CFB_RST_PULSE_NS 64
`endif

// ===== verilog/cfb_pkg.sv
// Types of the configuration fallback boot controller.
// Assumes cfb_defines.svh is on the include path.
package cfb_pkg;
  typedef enum logic [2:0] {CFB_RESET, CFB_CLEAR, CFB_LOAD, CFB_DONE, CFB_LOCK} cfb_state_e;
  typedef enum logic [1:0] {CFB_MODE_SPI, CFB_MODE_UP, CFB_MODE_DOWN, CFB_MODE_OTHER} cfb_mode_e;
  typedef struct packed {
    logic program_pin_n;
    logic jtag_program;
    logic int_prog_cmd;
    logic err_id;
    logic err_crc;
    logic err_wrap;
    logic wdt_expire;
    logic mem_clear_done;
    logic cfg_complete;
  } cfb_evt_s;
  typedef struct packed {
    logic rst_pulse;
    logic clr_req;
    logic init_b;
    logic done;
    logic [1:0] rs_o;
    logic rs_oe;
    logic rs_pu;
    logic rs_pd;
    logic [25:0] start_addr;
    logic read_en;
    logic wdt_en;
    logic int_prog_ignored;
  } cfb_pins_s;
  typedef struct packed {
    cfb_state_e st;
    logic [7:0] cnt;
    logic fb;
    logic fb_seen;
    logic from_ip;
    logic ip_seen;
    logic [15:0] hist;
    logic [31:0] ctrl;
    logic [27:0] wb;
    logic aw_v;
    logic [7:0] aw_a;
    logic w_v;
    logic [31:0] w_d;
    logic [3:0] w_s;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    cfb_pins_s pins;
  } cfb_state_s;
endpackage

// ===== verilog/cfb_fallback_boot.sv
// Fallback reboot controller of the configuration engine, AXI4-Lite slave.
// Assumes event inputs synchronous to mclk and a flash reader that obeys its outputs.
// Operation
// R01: Reboot pulse resets configuration, keeps reboot state
// R02: Pulse drops init and done, then clears
// R03: Pull-ups first load, pull-downs after done
// R04: On error pulse reset, drive select 00
// R05: Id, checksum, watchdog, wrap errors trigger fallback
// R06: Watchdog in monitor mode triggers after done
// R07: Second failure stops, init and done low
// R08: No fallback if encrypted, slave parallel, disabled
// R09: Ignore embedded program command during fallback
// R10: Watchdog off during and after fallback
// R11: Warm boot after fallback re-enables watchdog
// R12: Upward parallel fallback address starts at 0
// R13: Downward parallel fallback address 0x000FFFFF
// R14: Serial flash fallback read address is 0
// R15: System stores safe image at select 00
// R16: Program pin, JTAG program, power-on start config
// R17: Keep reading flash until done goes high
// R18: System pads images for lock waits
// R19: Software checks history after fallback
// R20: History is two entries, newest in entry zero
// R21: Default start address by flash mode
// R22: Fallback load remembered, second failure locks
//
// Implementation choices: the AXI4-Lite slave port and the address map.
`include "cfb_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module cfb_fallback_boot #(
  parameter int RST_PULSE_NS = `CFB_RST_PULSE_NS
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire cfb_pkg::cfb_evt_s evt,
  output cfb_pkg::cfb_pins_s pins
);
  // ******************************
  // Derived counts
  // ******************************
  localparam int RST_CYC_I = (RST_PULSE_NS + `CFB_CLK_PERIOD_NS - 1) / `CFB_CLK_PERIOD_NS;
  localparam logic [7:0] RST_CYC = (RST_CYC_I < 1) ? 8'h01 : 8'(RST_CYC_I);

  // ******************************
  // Helpers
  // ******************************
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [15:0] push(input logic [15:0] h, input logic [7:0] rec);
    return {h[7:0], rec};
  endfunction

  function automatic logic [25:0] def_addr(input cfb_pkg::cfb_mode_e m);
    return (m == cfb_pkg::CFB_MODE_DOWN) ? `CFB_ADDR_DOWN_DEF : `CFB_ADDR_UP_DEF;
  endfunction

  function automatic logic [7:0] word_addr(input logic [7:0] a);
    return {a[7:2], 2'h0};
  endfunction

  function automatic logic [7:0] hist_rec(input logic [2:0] errs, input logic wto, input logic ipc, input logic fb,
                                          input logic ok);
    return {1'b0, errs, wto, ipc, fb, ok};
  endfunction

  // ******************************
  // Reset release
  // ******************************
  logic [1:0] rst_sync_r;
  logic rst_n;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  // ******************************
  // State
  // ******************************
  cfb_pkg::cfb_state_s s_r;
  cfb_pkg::cfb_state_s s_nxt;
  cfb_pkg::cfb_mode_e mode;
  logic fb_ok;
  logic wdt_on;
  assign mode = cfb_pkg::cfb_mode_e'(s_r.ctrl[`CFB_CTRL_MODE +: 2]);
  assign fb_ok = !s_r.ctrl[`CFB_CTRL_FBDIS] && !s_r.ctrl[`CFB_CTRL_ENCRYPT] && !s_r.ctrl[`CFB_CTRL_SLVPAR]; // see R08
  assign wdt_on = s_r.ctrl[`CFB_CTRL_WDT_EN] && !s_r.fb_seen; // see R10

  always_comb begin
    logic ip_req;
    logic err_load;
    logic err_user;
    logic wto;
    logic [31:0] rd;
    logic [1:0] rr;
    ip_req = 1'b0;
    err_load = 1'b0;
    err_user = 1'b0;
    wto = 1'b0;
    rd = 32'h0000_0000;
    rr = `CFB_RESP_OKAY;
    s_nxt = s_r;
    s_nxt.pins.int_prog_ignored = 1'b0;

    // ******************************
    // Register writes
    // ******************************
    // Address and data are latched separately, in either order
    if (s_axi_awvalid && s_axi_awready) begin
      s_nxt.aw_v = 1'b1;
      s_nxt.aw_a = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_nxt.w_v = 1'b1;
      s_nxt.w_d = s_axi_wdata;
      s_nxt.w_s = s_axi_wstrb;
    end
    if (s_r.aw_v && s_r.w_v) begin
      s_nxt.aw_v = 1'b0;
      s_nxt.w_v = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = `CFB_RESP_OKAY;
      case (word_addr(s_r.aw_a))
        `CFB_ADDR_CTRL: begin
          s_nxt.ctrl = merge(s_r.ctrl, s_r.w_d, s_r.w_s) & 32'h0000_0337;
        end
        `CFB_ADDR_WBSTART: begin
          s_nxt.wb = 28'(merge({4'h0, s_r.wb}, s_r.w_d, s_r.w_s));
        end
        `CFB_ADDR_CMD: begin
          ip_req = s_r.w_s[0] && s_r.w_d[`CFB_CMD_INT_PROG];
        end
        `CFB_ADDR_STATUS, `CFB_ADDR_HIST: begin
        end
        default: begin
          s_nxt.bresp = `CFB_RESP_SLVERR;
        end
      endcase
    end
    if (s_r.bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
    end
    if (s_r.rvalid && s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
    end
    // ******************************
    // Register reads
    // ******************************
    if (s_axi_arvalid && s_axi_arready) begin
      case (word_addr(s_axi_araddr))
        `CFB_ADDR_CTRL: begin
          rd = s_r.ctrl;
        end
        `CFB_ADDR_WBSTART: begin
          rd = {4'h0, s_r.wb};
        end
        `CFB_ADDR_CMD: begin
          rd = 32'h0000_0000;
        end
        `CFB_ADDR_STATUS: begin
          rd = {22'h00_0000, s_r.pins.wdt_en, s_r.fb_seen, s_r.fb, s_r.pins.done, s_r.pins.init_b, 2'h0, s_r.st};
        end
        `CFB_ADDR_HIST: begin
          rd = {16'h0000, s_r.hist};
        end
        default: begin
          rr = `CFB_RESP_SLVERR;
        end
      endcase
      s_nxt.rvalid = 1'b1;
      s_nxt.rdata = rd;
      s_nxt.rresp = rr;
    end

    // ******************************
    // Configuration sequencing
    // ******************************
    ip_req = ip_req || evt.int_prog_cmd;
    wto = evt.wdt_expire && wdt_on;
    err_load = (s_r.st == cfb_pkg::CFB_LOAD) && (evt.err_id || evt.err_crc || evt.err_wrap || wto); // see R05
    err_user = (s_r.st == cfb_pkg::CFB_DONE) && wto && s_r.ctrl[`CFB_CTRL_WDT_MON]; // see R06

    if (!evt.program_pin_n || evt.jtag_program) begin
      // Full restart clears the fallback record but keeps the history
      s_nxt.st = cfb_pkg::CFB_RESET; // see R16
      s_nxt.cnt = 8'h00;
      s_nxt.fb = 1'b0;
      s_nxt.fb_seen = 1'b0;
      s_nxt.from_ip = 1'b0;
      s_nxt.ip_seen = 1'b0;
      s_nxt.pins.rs_oe = 1'b0;
      s_nxt.pins.start_addr = def_addr(mode); // see R21
    end else if (err_load || err_user) begin
      s_nxt.hist = push(s_r.hist, hist_rec({evt.err_wrap, evt.err_crc, evt.err_id}, wto,
                                           s_r.ip_seen, s_r.fb, 1'b1)); // see R20
      if (s_r.fb || !fb_ok) begin
        s_nxt.st = cfb_pkg::CFB_LOCK; // see R07, R22, R08
      end else begin
        s_nxt.st = cfb_pkg::CFB_RESET; // see R04
        s_nxt.cnt = 8'h00;
        s_nxt.fb = 1'b1; // see R22
        s_nxt.fb_seen = 1'b1; // see R10
        s_nxt.from_ip = 1'b0;
        s_nxt.ip_seen = 1'b0;
        s_nxt.pins.rs_oe = 1'b1; // see R04
        s_nxt.pins.rs_o = `CFB_RS_FALLBACK; // see R04
        case (mode)
          cfb_pkg::CFB_MODE_DOWN: begin
            s_nxt.pins.start_addr = `CFB_ADDR_DOWN_FB; // see R13
          end
          cfb_pkg::CFB_MODE_UP: begin
            s_nxt.pins.start_addr = `CFB_ADDR_UP_DEF; // see R12
          end
          default: begin
            s_nxt.pins.start_addr = `CFB_ADDR_UP_DEF; // see R14
          end
        endcase
      end
    end else begin
      case (s_r.st)
        cfb_pkg::CFB_RESET: begin
          s_nxt.cnt = s_r.cnt + 8'h01;
          if (s_r.cnt == RST_CYC - 8'h01) begin
            s_nxt.st = cfb_pkg::CFB_CLEAR; // see R02
          end
        end
        cfb_pkg::CFB_CLEAR: begin
          if (evt.mem_clear_done) begin
            s_nxt.st = cfb_pkg::CFB_LOAD;
          end
        end
        cfb_pkg::CFB_LOAD: begin
          if (evt.cfg_complete) begin
            s_nxt.st = cfb_pkg::CFB_DONE; // see R17
            s_nxt.pins.rs_oe = 1'b0;
            s_nxt.hist = push(s_r.hist, hist_rec(3'h0, 1'b0, s_r.ip_seen || (ip_req && s_r.fb),
                                                 s_r.fb, 1'b1)); // see R20
            if (s_r.from_ip && !s_r.fb) begin
              s_nxt.fb_seen = 1'b0; // see R11
            end
          end else if (ip_req && s_r.fb) begin
            s_nxt.ip_seen = 1'b1; // see R09
            s_nxt.pins.int_prog_ignored = 1'b1; // see R09
          end else if (ip_req) begin
            s_nxt.ip_seen = 1'b1;
          end
        end
        cfb_pkg::CFB_DONE: begin
          if (ip_req) begin
            // Warm boot keeps history and fb_seen, clears fb, takes start address and select from the warm boot register
            s_nxt.st = cfb_pkg::CFB_RESET; // see R01
            s_nxt.cnt = 8'h00;
            s_nxt.fb = 1'b0;
            s_nxt.from_ip = 1'b1;
            s_nxt.ip_seen = 1'b1;
            s_nxt.pins.rs_oe = 1'b1;
            s_nxt.pins.rs_o = s_r.wb[`CFB_WB_RS +: 2];
            s_nxt.pins.start_addr = s_r.wb[25:0];
          end
        end
        cfb_pkg::CFB_LOCK: begin
          s_nxt.st = cfb_pkg::CFB_LOCK; // see R07
        end
        default: begin
          s_nxt.st = cfb_pkg::CFB_LOCK;
        end
      endcase
    end

    // ******************************
    // Pin decode
    // ******************************
    // Pins follow the next state so they come straight from flops
    s_nxt.pins.rst_pulse = (s_nxt.st == cfb_pkg::CFB_RESET); // see R01
    s_nxt.pins.clr_req = (s_nxt.st == cfb_pkg::CFB_CLEAR); // see R02
    s_nxt.pins.init_b = (s_nxt.st == cfb_pkg::CFB_LOAD) || (s_nxt.st == cfb_pkg::CFB_DONE); // see R02, R07
    s_nxt.pins.done = (s_nxt.st == cfb_pkg::CFB_DONE); // see R02, R07
    s_nxt.pins.read_en = (s_nxt.st == cfb_pkg::CFB_LOAD); // see R17
    s_nxt.pins.rs_pu = !s_nxt.pins.rs_oe && (s_nxt.st != cfb_pkg::CFB_DONE); // see R03
    s_nxt.pins.rs_pd = !s_nxt.pins.rs_oe && (s_nxt.st == cfb_pkg::CFB_DONE); // see R03
    s_nxt.pins.wdt_en = s_nxt.ctrl[`CFB_CTRL_WDT_EN] && !s_nxt.fb_seen; // see R10, R11
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
      s_r.st <= cfb_pkg::CFB_RESET; // see R16
      s_r.ctrl <= `CFB_CTRL_RESET;
      s_r.wb <= `CFB_WB_RESET;
      s_r.pins.rst_pulse <= 1'b1;
      s_r.pins.rs_pu <= 1'b1;
      s_r.pins.start_addr <= `CFB_ADDR_UP_DEF;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ******************************
  // Outputs
  // ******************************
  assign s_axi_awready = !s_r.aw_v && !s_r.bvalid;
  assign s_axi_wready = !s_r.w_v && !s_r.bvalid;
  assign s_axi_bvalid = s_r.bvalid;
  assign s_axi_bresp = s_r.bresp;
  assign s_axi_arready = !s_r.rvalid;
  assign s_axi_rvalid = s_r.rvalid;
  assign s_axi_rdata = s_r.rdata;
  assign s_axi_rresp = s_r.rresp;

  // ******************************
  // Pin outputs
  // ******************************
  assign pins = s_r.pins;
endmodule
`default_nettype wire

// ===== verification/cfb_fallback_boot_checker.sv
// Assertion checker of the fallback boot controller.
// Assumes the controller ports, bound at the foot.
`timescale 1ns/10ps
`default_nettype none
module cfb_fallback_boot_checker #(
  parameter int RST_PULSE_NS = 64
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire cfb_pkg::cfb_evt_s evt,
  input wire cfb_pkg::cfb_pins_s pins
);
  // ****************
  // Properties
  // ****************
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  logic prg;
  logic err;
  assign prg = !evt.program_pin_n || evt.jtag_program;
  assign err = evt.err_id || evt.err_crc || evt.err_wrap;
  chk_pulse_len: assert property ($rose(pins.rst_pulse) |-> pins.rst_pulse [*8] ##1 !pins.rst_pulse)
    else $error("reboot pulse length wrong");
  chk_pulse_pins: assert property (pins.rst_pulse |-> !pins.init_b && !pins.done && !pins.read_en)
    else $error("init or done high in pulse");
  chk_clear_next: assert property ($fell(pins.rst_pulse) |-> pins.clr_req)
    else $error("no clear after pulse");
  chk_err_stop: assert property (pins.read_en && err && !prg |=> !pins.read_en && !pins.init_b)
    else $error("error did not stop load");
  chk_rs_zero: assert property ($rose(pins.rst_pulse) && $past(err) && $past(pins.read_en) && !$past(prg)
    |-> pins.rs_oe && pins.rs_o == 2'h0)
    else $error("fallback select not driven low");
  chk_pull_up: assert property (!pins.rs_oe && !pins.done |-> pins.rs_pu && !pins.rs_pd)
    else $error("pull-up missing");
  chk_pull_down: assert property (pins.done && !pins.rs_oe |-> pins.rs_pd && !pins.rs_pu)
    else $error("pull-down missing");
  chk_keep_read: assert property (pins.read_en && !err && !prg && !evt.cfg_complete && !evt.wdt_expire
    |=> pins.read_en)
    else $error("flash reading stopped early");
  chk_ign_cmd: assert property (pins.int_prog_ignored |-> $past(evt.int_prog_cmd) ##1 !pins.rst_pulse)
    else $error("ignored command rebooted");
  chk_lock_hold: assert property (!pins.init_b && !pins.rst_pulse && !pins.clr_req && !prg
    |=> !pins.init_b && !pins.done)
    else $error("lockout released");
  cov_fallback: cover property ($rose(pins.rs_oe) && pins.rs_o == 2'h0);
  cov_ignored: cover property (pins.int_prog_ignored);
  cov_done: cover property ($rose(pins.done));
endmodule
bind cfb_fallback_boot cfb_fallback_boot_checker #(.RST_PULSE_NS(RST_PULSE_NS)) i_chk (.mclk(mclk),
  .resetn(resetn), .evt(evt), .pins(pins));
`default_nettype wire

// ===== verification/cfb_flash_model.sv
// Flash and load engine model: memory clear, image loads, scripted failures.
// Assumes controller pins and bench controls on mclk.
`timescale 1ns/10ps
`default_nettype none
module cfb_flash_model (
  input wire logic mclk,
  input wire cfb_pkg::cfb_pins_s pins,
  input wire logic [1:0] fail,
  input wire logic fail_safe,
  input wire logic [3:0] dly,
  output logic clr_done,
  output logic cmpl,
  output logic [2:0] err,
  output logic [25:0] load_addr,
  output logic [1:0] load_rs
);
  // ****************
  // Behaviour
  // ****************
  logic [3:0] cnt = 4'h0;
  logic [1:0] rs;
  logic busy;
  assign rs = pins.rs_oe ? pins.rs_o : (pins.rs_pu ? 2'h3 : 2'h0);
  assign busy = clr_done || cmpl || err != 3'h0;
  initial begin
    {clr_done, cmpl, err, load_addr, load_rs} = '0;
  end
  always @(posedge mclk) begin
    clr_done <= 1'b0;
    cmpl <= 1'b0;
    err <= 3'h0;
    cnt <= ((pins.clr_req || pins.read_en) && !busy && cnt != dly) ? cnt + 4'h1 : 4'h0;
    if (pins.read_en && cnt == 4'h0) begin
      load_addr <= pins.start_addr;
      load_rs <= rs;
    end
    if (pins.clr_req && cnt == dly)
      clr_done <= 1'b1;
    // Image at select 00 is the safe one; it fails only when told to
    if (pins.read_en && cnt == dly) begin
      if (fail != 2'h0 && (rs != 2'h0 || fail_safe))
        err <= 3'h1 << (fail - 2'h1);
      else
        cmpl <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// ===== verification/tb_config_fallback_boot.sv
// Self-checking bench of the fallback boot controller.
// Assumes the flash model and the bound checker are compiled before it.
`timescale 1ns/10ps
`default_nettype none
module tb_config_fallback_boot;
  // ****************
  // Bench
  // ****************
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid, clr_done, cmpl;
  logic [1:0] bresp, rresp, load_rs;
  logic [31:0] rdata;
  logic prg_n = 1'b1, jprg = 1'b0, icmd = 1'b0, wdt = 1'b0, fail_safe = 1'b0;
  logic [1:0] fail = 2'h0;
  logic [3:0] dly = 4'h3;
  logic [2:0] err;
  logic [25:0] load_addr;
  cfb_pkg::cfb_evt_s evt;
  cfb_pkg::cfb_pins_s pins;
  int failures = 0, total_checks = 0;
  int hq[$] = '{0, 0};
  always #4 mclk = ~mclk;
  assign evt = '{prg_n, jprg, icmd, err[0], err[1], err[2], wdt, clr_done, cmpl};
  cfb_fallback_boot i_dut (.mclk(mclk), .resetn(resetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .evt(evt), .pins(pins));
  cfb_flash_model i_flash (.mclk(mclk), .pins(pins), .fail(fail), .fail_safe(fail_safe), .dly(dly),
    .clr_done(clr_done), .cmpl(cmpl), .err(err), .load_addr(load_addr), .load_rs(load_rs));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic hang(input string nm);
    failures++;
    $display("[ERR] %s expected answer seen timeout", nm);
    print_verdict();
  endtask
  task automatic axi(input bit wr, input logic [7:0] a, input logic [31:0] d, input logic [1:0] er,
    output logic [31:0] q);
    int n;
    @(posedge mclk);
    awaddr <= a;
    araddr <= a;
    wdata <= d;
    {awvalid, wvalid, bready, arvalid, rready} <= wr ? 5'h1C : 5'h03;
    for (n = 0; n < 64; n++) begin
      @(posedge mclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (arvalid && arready) arvalid <= 1'b0;
      if ((wr && bvalid) || (!wr && rvalid)) break;
    end
    q = rdata;
    chk("response", wr ? bresp : rresp, er);
    bready <= 1'b0;
    rready <= 1'b0;
    if (n == 64) hang("bus");
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    axi(1, a, d, 2'h0, q);
  endtask
  task automatic settle(input string nm, input int st, input logic [31:0] w, input bit inj);
    logic [31:0] d;
    int n;
    int ig;
    bit want;
    want = inj;
    ig = 0;
    repeat (2) @(posedge mclk);
    for (n = 0; n < 400; n++) begin
      @(posedge mclk);
      ig += pins.int_prog_ignored;
      icmd <= inj && pins.read_en && pins.rs_oe && pins.rs_o == 2'h0;
      if (inj && pins.read_en && pins.rs_oe && pins.rs_o == 2'h0) inj = 0;
      if (!pins.rst_pulse && !pins.clr_req && !pins.read_en) break;
    end
    if (n == 400) hang(nm);
    chk({nm, " ignored"}, ig, want);
    axi(0, 8'h0C, 0, 2'h0, d);
    chk({nm, " status"}, d & 32'h0000_0267, w | st | (st == 3 ? 32'h0000_0060 : 0));
    axi(0, 8'h10, 0, 2'h0, d);
    chk({nm, " history"}, d & 32'h0000_FFFF, {hq[1][7:0], hq[0][7:0]});
    $display("%s done", nm);
  endtask
  task automatic pulse_prog(input bit jtag);
    @(posedge mclk);
    prg_n <= jtag;
    jprg <= jtag;
    @(posedge mclk);
    prg_n <= 1'b1;
    jprg <= 1'b0;
  endtask
  initial begin
    logic [31:0] d;
    logic [25:0] a;
    int k;
    void'($urandom(7424));
    repeat (10) @(posedge mclk);
    chk("reset pulls", {pins.rs_pu, pins.rs_oe, pins.done}, 32'h0000_0004);
    resetn <= 1'b1;
    hq.push_front(1);
    settle("power-on", 3, 0, 0);
    chk("power-on select", load_rs, 2'h3);
    chk("power-on address", load_addr, 0);
    for (k = 0; k < 5; k++) begin
      axi(0, 8'(4 * k + 4 * (k / 4)), 0, k == 4 ? 2'h2 : 2'h0, d);
      chk("register reset", d & 32'h0000_FFFF, k == 3 ? 32'h0000_0063 : 32'h0000_0000);
    end
    axi(1, 8'h14, 32'hFFFF_FFFF, 2'h2, d);
    wr(8'h00, 32'h0000_0300);
    @(posedge mclk);
    chk("watchdog on", pins.wdt_en, 1'b1);
    wdt <= 1'b1;
    @(posedge mclk);
    wdt <= 1'b0;
    hq.push_front(32'h0000_0009);
    hq.push_front(32'h0000_0003);
    settle("watchdog fallback", 3, 0, 0);
    chk("fallback select", load_rs, 2'h0);
    for (k = 0; k < 3; k++) begin
      a = 26'($urandom);
      dly <= 4'($urandom_range(9, 2));
      fail <= 2'(k + 1);
      wr(8'h00, 32'(k << 4));
      wr(8'h04, {4'h0, 2'h1, a});
      wr(8'h08, 32'h0000_0001);
      hq.push_front(32'h0000_0005 | (32'h0000_0010 << k));
      hq.push_front(k == 1 ? 32'h0000_0007 : 32'h0000_0003);
      settle("error fallback", 3, 0, k == 1);
      chk("fallback select", load_rs, 2'h0);
      chk("fallback address", load_addr, k == 2 ? 26'h00F_FFFF : 26'h000_0000);
    end
    fail <= 2'h0;
    wstrb <= 4'h2;
    wr(8'h00, 32'hFFFF_FF00);
    wstrb <= 4'hF;
    axi(0, 8'h00, 0, 2'h0, d);
    chk("strobe merge", d, 32'h0000_0320);
    wr(8'h04, {4'h0, 2'h1, a});
    wr(8'h08, 32'h0000_0001);
    hq.push_front(32'h0000_0005);
    settle("warm boot", 3, 32'h0000_0200, 0);
    chk("warm address", load_addr, a);
    fail <= 2'h2;
    fail_safe <= 1'b1;
    wr(8'h08, 32'h0000_0001);
    hq.push_front(32'h0000_0025);
    hq.push_front(32'h0000_0023);
    settle("second failure", 4, 0, 0);
    wr(8'h00, 32'h0000_0000);
    for (k = 0; k < 3; k++) begin
      fail <= 2'h0;
      fail_safe <= 1'b0;
      pulse_prog(k[0]);
      hq.push_front(1);
      settle("program restart", 3, 0, 0);
      chk("program select", load_rs, 2'h3);
      fail <= 2'h2;
      fail_safe <= 1'($urandom);
      wr(8'h00, 32'h0000_0001 << k);
      wr(8'h08, 32'h0000_0001);
      hq.push_front(32'h0000_0025);
      settle("fallback barred", 4, 0, 0);
      chk("no fallback load", load_rs, 2'h1);
    end
    print_verdict();
  end
endmodule
`default_nettype wire
